// ===== pmc_event_pkg.sv
// constants and carrier types for the branch and dispatch event counter
package pmc_event_pkg;

    // counter geometry
    localparam int COUNT_W = 40;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 40'h0;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 40'h1;
    localparam int PORT_N = 3;

    // event codes
    localparam logic [7:0] EV_IND_BRANCH_MISP = 8'h8e;
    localparam logic [7:0] EV_RETURN_EXEC = 8'h8f;
    localparam logic [7:0] EV_RETURN_MISP = 8'h90;
    localparam logic [7:0] EV_RETURN_DECODE_MISP = 8'h91;
    localparam logic [7:0] EV_CALL_EXEC = 8'h92;
    localparam logic [7:0] EV_CALL_MISP = 8'h93;
    localparam logic [7:0] EV_IND_CALL = 8'h94;
    localparam logic [7:0] EV_BUBBLE_FIRST = 8'h97;
    localparam logic [7:0] EV_BUBBLE_SECOND = 8'h98;
    localparam logic [7:0] EV_DISPATCH_TOTAL = 8'ha0;
    localparam logic [7:0] EV_DISPATCH_PORT = 8'ha1;

    // unit masks
    localparam logic [7:0] UMASK_NONE = 8'h00;
    localparam logic [7:0] UMASK_PORT_ZERO = 8'h01;
    localparam logic [7:0] UMASK_PORT_ONE = 8'h02;
    localparam logic [7:0] UMASK_PORT_TWO = 8'h04;

    // dispatch limits
    localparam logic [2:0] DISPATCH_MAX = 3'h6;
    localparam logic [2:0] INC_NONE = 3'h0;
    localparam logic [2:0] INC_ONE = 3'h1;

    // decoded event source
    typedef enum logic [3:0] {
        SRC_NONE,
        SRC_IND_BRANCH_MISP,
        SRC_RETURN_EXEC,
        SRC_RETURN_MISP,
        SRC_RETURN_DECODE_MISP,
        SRC_CALL_EXEC,
        SRC_CALL_MISP,
        SRC_IND_CALL,
        SRC_BUBBLE_FIRST,
        SRC_BUBBLE_SECOND,
        SRC_DISPATCH_TOTAL,
        SRC_DISPATCH_PORT
    } source_e;

    // per-cycle branch strobes from the pipeline
    typedef struct packed {
        logic ind_branch_misp;
        logic return_exec;
        logic return_misp;
        logic return_decode_misp;
        logic call_exec;
        logic call_misp;
        logic ind_call;
        logic taken_cluster;
        logic target_unaligned;
    } branch_strobe_s;

    // per-cycle dispatch strobes from the pipeline
    typedef struct packed {
        logic [2:0] total;
        logic [PORT_N-1:0] port_busy;
    } dispatch_strobe_s;

    // selector as programmed by software
    typedef struct packed {
        logic [7:0] event_code;
        logic [7:0] unit_mask;
        logic enable;
    } select_s;

    // whole state of the counter block
    typedef struct packed {
        logic [COUNT_W-1:0] count;
        logic matched;
        logic [2:0] last_inc;
    } counter_state_s;

endpackage

// ===== branch_dispatch_event_select.sv
// event selector and counter for branch and micro-op dispatch events
`timescale 1ns/1ps

module branch_dispatch_event_select
    import pmc_event_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // selector and counter control
    input wire select_s sel,
    input wire logic first_counter,
    input wire logic counter_clear,
    // pipeline strobes
    input wire branch_strobe_s branch,
    input wire dispatch_strobe_s dispatch,
    // counter view
    output logic [COUNT_W-1:0] count_value,
    output logic event_matched,
    output logic [2:0] last_increment
);

    counter_state_s state_reg;
    counter_state_s state_next;
    source_e source;
    logic [PORT_N-1:0] port_pick;
    logic port_hit;
    logic bubble_first;
    logic bubble_second;
    logic [2:0] inc;
    logic live;

    // map a code and mask pair onto a source; used by logic and checks
    function automatic source_e decode_source(
        input logic [7:0] code,
        input logic [7:0] mask,
        input logic first
    );
        source_e src;
        src = SRC_NONE;
        if (mask == UMASK_NONE) begin
            unique case (code)
                EV_IND_BRANCH_MISP: src = SRC_IND_BRANCH_MISP;
                EV_RETURN_EXEC: src = SRC_RETURN_EXEC;
                EV_RETURN_MISP: src = SRC_RETURN_MISP;
                EV_RETURN_DECODE_MISP: src = SRC_RETURN_DECODE_MISP;
                EV_CALL_EXEC: src = SRC_CALL_EXEC;
                EV_CALL_MISP: src = SRC_CALL_MISP;
                EV_IND_CALL: src = SRC_IND_CALL;
                EV_BUBBLE_FIRST: src = SRC_BUBBLE_FIRST;
                EV_BUBBLE_SECOND: src = SRC_BUBBLE_SECOND;
                EV_DISPATCH_TOTAL: src = SRC_DISPATCH_TOTAL;
                default: src = SRC_NONE;
            endcase
        end else if (code == EV_DISPATCH_PORT && first &&
                     (mask == UMASK_PORT_ZERO || mask == UMASK_PORT_ONE ||
                      mask == UMASK_PORT_TWO)) begin
            src = SRC_DISPATCH_PORT;
        end
        return src;
    endfunction

    // per-port mask match; a one-hot mask on bits 0 to 2 selects exactly one port
    generate
        for (genvar p = 0; p < PORT_N; p++) begin : g_port
            assign port_pick[p] = (sel.unit_mask == (UMASK_PORT_ZERO << p));
        end
    endgenerate

    // a port strobe is one bit, so a port never adds more than one
    assign port_hit = |(port_pick & dispatch.port_busy);

    // clustered taken branches go to the first share; an unaligned target
    // alone goes to the second, so the sum counts each penalty once
    assign bubble_first = branch.taken_cluster;
    assign bubble_second = branch.target_unaligned &
                           ~branch.taken_cluster;

    // source decode and the counter is only live while enabled
    assign source = decode_source(sel.event_code, sel.unit_mask,
                                  first_counter);
    assign live = sel.enable & ~counter_clear;

    // increment for this cycle
    always_comb begin
        inc = INC_NONE;
        unique case (source)
            SRC_NONE: inc = INC_NONE;
            SRC_IND_BRANCH_MISP: inc = {2'h0, branch.ind_branch_misp};
            SRC_RETURN_EXEC: inc = {2'h0, branch.return_exec};
            SRC_RETURN_MISP: inc = {2'h0, branch.return_misp};
            SRC_RETURN_DECODE_MISP: begin
                inc = {2'h0, branch.return_decode_misp};
            end
            SRC_CALL_EXEC: inc = {2'h0, branch.call_exec};
            SRC_CALL_MISP: inc = {2'h0, branch.call_misp};
            SRC_IND_CALL: inc = {2'h0, branch.ind_call};
            SRC_BUBBLE_FIRST: inc = {2'h0, bubble_first};
            SRC_BUBBLE_SECOND: inc = {2'h0, bubble_second};
            SRC_DISPATCH_TOTAL: begin
                // clamp guards against a bad pipeline count above six
                if (dispatch.total > DISPATCH_MAX) begin
                    inc = DISPATCH_MAX;
                end else begin
                    inc = dispatch.total;
                end
            end
            SRC_DISPATCH_PORT: inc = {2'h0, port_hit};
        endcase
    end

    // next state; clear beats counting, it is a load and not a flag
    always_comb begin
        state_next = state_reg;
        state_next.matched = sel.enable && (source != SRC_NONE);
        if (counter_clear) begin
            state_next.count = COUNT_RESET;
            state_next.last_inc = INC_NONE;
        end else if (sel.enable) begin
            state_next.count = state_reg.count + {37'h0, inc};
            state_next.last_inc = inc;
        end else begin
            state_next.last_inc = INC_NONE;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg.count <= COUNT_RESET;
            state_reg.matched <= 1'b0;
            state_reg.last_inc <= INC_NONE;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state register
    assign count_value = state_reg.count;
    assign event_matched = state_reg.matched;
    assign last_increment = state_reg.last_inc;

    // checks on the counter behaviour
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // helper: selection as it stood in a cycle; a let expands in place, so
    // sel and live are sampled like every other term of the property
    let picked(code, mask) = live && sel.event_code == code &&
        sel.unit_mask == mask;

    sequence counted_once;
        count_value == $past(count_value) + COUNT_ONE;
    endsequence

    sequence held_still;
        count_value == $past(count_value);
    endsequence

    property adds_one(logic cond);
        cond |=> counted_once;
    endproperty

    property adds_none(logic cond);
        cond |=> held_still;
    endproperty

    ind_branch_count_a: assert property (
        adds_one(picked(EV_IND_BRANCH_MISP, UMASK_NONE) &&
                 branch.ind_branch_misp))
        else $error("indirect branch mispredict not counted");

    return_exec_count_a: assert property (
        adds_one(picked(EV_RETURN_EXEC, UMASK_NONE) && branch.return_exec))
        else $error("executed return not counted");

    return_misp_count_a: assert property (
        picked(EV_RETURN_MISP, UMASK_NONE) |=>
        (count_value - $past(count_value)) ==
        {39'h0, $past(branch.return_misp)})
        else $error("return mispredict count wrong");

    return_decode_count_a: assert property (
        adds_one(picked(EV_RETURN_DECODE_MISP, UMASK_NONE) &&
                 branch.return_decode_misp))
        else $error("decode mispredicted return not counted");

    call_exec_count_a: assert property (
        adds_one(picked(EV_CALL_EXEC, UMASK_NONE) && branch.call_exec))
        else $error("executed call not counted");

    call_misp_count_a: assert property (
        adds_one(picked(EV_CALL_MISP, UMASK_NONE) && branch.call_misp))
        else $error("mispredicted call not counted");

    ind_call_count_a: assert property (
        picked(EV_IND_CALL, UMASK_NONE) && !branch.ind_call |=>
        held_still)
        else $error("indirect call counted without strobe");

    bubble_share_a: assert property (
        adds_none(picked(EV_BUBBLE_SECOND, UMASK_NONE) &&
                  branch.taken_cluster))
        else $error("second bubble share took a clustered penalty");

    bubble_cause_a: assert property (
        adds_one(picked(EV_BUBBLE_SECOND, UMASK_NONE) &&
                 branch.target_unaligned && !branch.taken_cluster))
        else $error("unaligned target bubble not counted");

    dispatch_total_a: assert property (
        picked(EV_DISPATCH_TOTAL, UMASK_NONE) &&
        dispatch.total <= DISPATCH_MAX |=>
        count_value == $past(count_value) + {37'h0, $past(dispatch.total)}
        ##0 last_increment == $past(dispatch.total))
        else $error("dispatched micro-op total not added");

    port_one_count_a: assert property (
        adds_one(picked(EV_DISPATCH_PORT, UMASK_PORT_ONE) &&
                 first_counter && dispatch.port_busy[1]))
        else $error("port one dispatch cycle not counted");

    port_single_a: assert property (
        decode_source(sel.event_code, sel.unit_mask, first_counter) ==
        SRC_DISPATCH_PORT && live |=> last_increment <= INC_ONE)
        else $error("port event added more than one");

    port_first_only_a: assert property (
        adds_none(live && sel.event_code == EV_DISPATCH_PORT &&
                  !first_counter))
        else $error("port event counted on another counter");

    unsupported_still_a: assert property (
        live && decode_source(sel.event_code, sel.unit_mask,
                              first_counter) == SRC_NONE
        |=> held_still ##0 !event_matched)
        else $error("unsupported selection moved the counter");

    clear_zero_a: assert property (
        counter_clear |=> count_value == COUNT_RESET ##1
        (count_value <= {37'h0, DISPATCH_MAX}))
        else $error("clear did not zero the counter");

    // further branch shares, port picks and selector side effects
    ind_call_hit_a: assert property (
        adds_one(picked(EV_IND_CALL, UMASK_NONE) && branch.ind_call))
        else $error("indirect call not counted");

    return_quiet_a: assert property (
        adds_none(picked(EV_RETURN_EXEC, UMASK_NONE) && !branch.return_exec))
        else $error("return count moved without a return");

    bubble_first_a: assert property (
        adds_one(picked(EV_BUBBLE_FIRST, UMASK_NONE) &&
                 branch.taken_cluster))
        else $error("clustered bubble not counted in first share");

    bubble_once_a: assert property (
        adds_none(picked(EV_BUBBLE_FIRST, UMASK_NONE) &&
                  branch.target_unaligned && !branch.taken_cluster))
        else $error("unaligned bubble also counted in first share");

    port_zero_count_a: assert property (
        adds_one(picked(EV_DISPATCH_PORT, UMASK_PORT_ZERO) &&
                 first_counter && dispatch.port_busy[0]))
        else $error("port zero dispatch cycle not counted");

    port_two_count_a: assert property (
        adds_one(picked(EV_DISPATCH_PORT, UMASK_PORT_TWO) &&
                 first_counter && dispatch.port_busy[2]))
        else $error("port two dispatch cycle not counted");

    dispatch_idle_a: assert property (
        picked(EV_DISPATCH_TOTAL, UMASK_NONE) && dispatch.total == INC_NONE
        |=> held_still ##0 last_increment == INC_NONE)
        else $error("idle dispatch cycle moved the counter");

    matched_flag_a: assert property (
        sel.enable && decode_source(sel.event_code, sel.unit_mask,
                                    first_counter) != SRC_NONE
        |=> event_matched)
        else $error("supported selection not flagged as matched");

    disabled_hold_a: assert property (
        !sel.enable && !counter_clear |=> held_still ##0
        last_increment == INC_NONE && !event_matched)
        else $error("disabled counter moved or flagged a match");

endmodule

// ===== pipeline_strobe_model.sv
// pipeline side: random branch and dispatch strobes, one set per cycle
`timescale 1ns/1ps

module pipeline_strobe_model
    import pmc_event_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // idle request from the bench
    input wire logic quiet,
    // strobes toward the counter
    output branch_strobe_s branch,
    output dispatch_strobe_s dispatch
);
    logic [31:0] r;

    // new strobes just after each rising edge; quiet gives idle stretches
    always @(posedge clk) begin
        r = $urandom;
        if (sys_rst || quiet) begin
            branch <= '0;
            dispatch <= '0;
        end else begin
            branch <= r[8:0];
            dispatch.total <= 3'(r[15:9] % 7);
            dispatch.port_busy <= r[18:16];
        end
    end
endmodule

// ===== testbench.sv
// self-checking bench for the branch and dispatch event counter
`timescale 1ns/1ps

module testbench
    import pmc_event_pkg::*;
;
    logic clk;
    logic sys_rst;
    select_s sel;
    logic first_counter;
    logic counter_clear;
    logic quiet;
    branch_strobe_s branch;
    dispatch_strobe_s dispatch;
    logic [COUNT_W-1:0] count_value;
    logic event_matched;
    logic [2:0] last_increment;
    int n_fail;
    int checked;
    logic [COUNT_W-1:0] exp_count;
    logic [2:0] exp_inc;
    logic exp_match;
    logic started;
    logic [31:0] r;
    logic [7:0] codes [14] = '{8'h8e, 8'h8f, 8'h90, 8'h91, 8'h92, 8'h93,
        8'h94, 8'h97, 8'h98, 8'ha0, 8'ha1, 8'h8d, 8'ha2, 8'h00};
    logic [7:0] masks [4] = '{8'h01, 8'h02, 8'h04, 8'h08};

    branch_dispatch_event_select DUT (.clk(clk), .sys_rst(sys_rst),
        .sel(sel), .first_counter(first_counter),
        .counter_clear(counter_clear), .branch(branch),
        .dispatch(dispatch), .count_value(count_value),
        .event_matched(event_matched), .last_increment(last_increment));

    pipeline_strobe_model pipe (.clk(clk), .sys_rst(sys_rst),
        .quiet(quiet), .branch(branch), .dispatch(dispatch));

    // supported code and mask pairs
    function automatic logic ref_match(select_s s, logic f);
        if (!s.enable)
            return 1'b0;
        case (s.event_code)
            8'h8e, 8'h8f, 8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h97, 8'h98,
            8'ha0: return s.unit_mask == 8'h00;
            8'ha1: return f && (s.unit_mask == 8'h01 ||
                s.unit_mask == 8'h02 || s.unit_mask == 8'h04);
            default: return 1'b0;
        endcase
    endfunction

    // amount the counter should add this cycle
    function automatic logic [2:0] ref_inc(select_s s, logic f,
        branch_strobe_s b, dispatch_strobe_s d);
        if (!ref_match(s, f))
            return 3'h0;
        case (s.event_code)
            8'h8e: return {2'h0, b.ind_branch_misp};
            8'h8f: return {2'h0, b.return_exec};
            8'h90: return {2'h0, b.return_misp};
            8'h91: return {2'h0, b.return_decode_misp};
            8'h92: return {2'h0, b.call_exec};
            8'h93: return {2'h0, b.call_misp};
            8'h94: return {2'h0, b.ind_call};
            8'h97: return {2'h0, b.taken_cluster};
            8'h98: return {2'h0, b.target_unaligned & ~b.taken_cluster};
            8'ha0: return d.total > 3'h6 ? 3'h6 : d.total;
            default: return {2'h0, d.port_busy[s.unit_mask[2] ? 2 :
                s.unit_mask[1] ? 1 : 0]};
        endcase
    endfunction

    task automatic check(input logic [COUNT_W-1:0] seen,
        input logic [COUNT_W-1:0] expected);
        checked++;
        if (seen !== expected) begin
            n_fail++;
            $display("Error at %0t: saw %0h expected %0h", $time, seen,
                expected);
        end
    endtask

    task automatic summarize;
        if (n_fail == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // clock at 200 MHz
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // outputs settle by the falling edge; compare, then step the model
    always @(negedge clk) begin
        if (started) begin
            check(count_value, exp_count);
            check(COUNT_W'(last_increment), COUNT_W'(exp_inc));
            check(COUNT_W'(event_matched), COUNT_W'(exp_match));
        end
        started = 1'b1;
        if (sys_rst || counter_clear) begin
            // a clear zeroes the count, the match flag still follows sel
            exp_count = '0;
            exp_inc = 3'h0;
            exp_match = !sys_rst && ref_match(sel, first_counter);
        end else begin
            exp_inc = ref_inc(sel, first_counter, branch, dispatch);
            exp_match = ref_match(sel, first_counter);
            exp_count = exp_count + COUNT_W'(exp_inc);
        end
    end

    // watchdog well beyond the expected run of about 2300 cycles
    initial begin
        #100us;
        n_fail++;
        summarize();
    end

    // main sequence: every code, wrong masks, disables, clears, resets
    initial begin
        n_fail = 0;
        checked = 0;
        started = 1'b0;
        exp_count = '0;
        sys_rst = 1'b1;
        sel = '0;
        first_counter = 1'b1;
        counter_clear = 1'b0;
        quiet = 1'b0;
        r = $urandom(19);
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        for (int rep = 0; rep < 4; rep++) begin
            for (int k = 0; k < 14; k++) begin
                repeat (40) @(posedge clk) begin
                    r = $urandom;
                    sel <= '{codes[k], codes[k] == 8'ha1 ? masks[r[1:0]] :
                        (r[4:0] == 5'h0 ? 8'h01 : 8'h00), r[7:5] != 3'h0};
                    first_counter <= r[8] | r[9];
                    counter_clear <= r[15:10] == 6'h0;
                    quiet <= r[16] & r[17];
                end
            end
            // reset again in mid-run; the strobe model drives idle strobes while sys_rst is high
            @(posedge clk) sys_rst <= 1'b1;
            repeat (2) @(posedge clk);
            sys_rst <= 1'b0;
        end
        repeat (3) @(posedge clk);
        summarize();
    end
endmodule
